// ### hw/stop_bar_sequence_controller.sv
`timescale 1ns/1ps
`include "stop_bar_cfg.svh"
// Behaviour
// - Press starts timers, bar off, leads on.
// - First backup timer runs 45 seconds.
// - Second backup timer runs 2 minutes.
// - Timer expiry acts like its sensor.
// - Sensor one: bar on, segment one off.
// - Sensor two: segment two off.
// - Early sensor two restores the bar.
// - Sensor two before timer one: all reset.
// - Override press ignores both sensors.
// - Override ends at timer two expiry.
// - One lamp failure leaves others unchanged.
// - Failed control device keeps lamps off.
// - Failure mode: on below limit, else off.
// - Failure mode selectable remotely.
// - Failsafe timer turns the red bar off later.
// - Failed indication holds until service.
// - Bar off, leads on within two seconds.
// - Lamp status reported within five seconds.
// - Report failed count and adjacency.
// - Combined: yellow at good, red low.
// - Combined failure: red or pulsing yellow.
// - Combined failure mode selectable locally.
// - Combined device failure: both lights off.
// - Segment one ends at sensor one.
module stop_bar_sequence_controller
    import stop_bar_pkg::*;
#(
    parameter int TICK_CYCLES = `CLK_HZ * `TICK_S
)(
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic STOP_BUTTON,
    input wire logic OVERRIDE_BUTTON,
    input wire logic SENSOR1,
    input wire logic SENSOR2,
    input wire logic COMM_FAIL,
    input wire logic LOCAL_SEL,
    input wire logic LOCAL_ON,
    input wire logic [7:0] LAMP_FAIL,
    input wire logic [7:0] DEV_FAIL,
    output logic [7:0] STOP_BAR_LAMP,
    output logic [7:0] GUARD_LAMP_ROW,
    output logic LEAD_SEG1,
    output logic LEAD_SEG2,
    output logic [7:0] LAMP_STATUS,
    output logic FAIL_IND
);
    import stop_bar_pkg::*;

    state_s r_reg;
    state_s r_next;
    in_t pins;
    in_t rise;
    lamp_t devf;
    lamp_t badf;
    logic tick;
    logic t1_exp;
    logic t2_exp;
    logic low_vis;
    logic fail_on;
    logic comm;
    logic combo;
    logic bar;
    logic [3:0] nfail;
    logic adj;
    logic wr_ok;
    logic [3:0] wr_idx;
    logic [31:0] rd_mux;

    assign pins = {DEV_FAIL, LAMP_FAIL, LOCAL_ON, LOCAL_SEL, COMM_FAIL,
                   SENSOR2, SENSOR1, OVERRIDE_BUTTON, STOP_BUTTON};
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = r_reg.rdata;
    assign STOP_BAR_LAMP = r_reg.red;
    assign GUARD_LAMP_ROW = r_reg.yel;
    assign LEAD_SEG1 = r_reg.seg1;
    assign LEAD_SEG2 = r_reg.seg2;
    assign LAMP_STATUS = r_reg.lstat;
    assign FAIL_IND = r_reg.failed;

    // ==========================================================
    // Next state
    always_comb
    begin
        r_next = r_reg;
        // Pins pass three flops; a level counts once the last two agree.
        r_next.s1 = pins;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < NIN; i++)
        begin
            if (r_reg.s2[i] == r_reg.s3[i])
            begin
                r_next.filt[i] = r_reg.s3[i];
            end
        end
        r_next.prev = r_reg.filt;
        rise = r_reg.filt & ~r_reg.prev;
        devf = r_reg.filt[`IN_DEV +: LAMPS];
        badf = devf | r_reg.filt[`IN_LAMP +: LAMPS];
        comm = r_reg.filt[`IN_COMM];
        combo = r_reg.ctrl[`CTRL_COMBO];
        low_vis = (r_reg.vis < `VIS_LIMIT_FT);

        // Second tick from the system clock.
        tick = (r_reg.presc == 26'(TICK_CYCLES - 1));
        r_next.presc = tick ? 26'h0000000 : r_reg.presc + 26'h0000001;
        if (tick)
        begin
            r_next.pulse = ~r_reg.pulse;
        end

        // ======================================================
        // Sequence
        t1_exp = (r_reg.t1 == `T1_S);
        t2_exp = (r_reg.t2 == `T2_S);
        if (tick && r_reg.seq == ARMED && !t1_exp)
        begin
            r_next.t1 = r_reg.t1 + 8'h01;
        end
        if (tick && r_reg.seq != IDLE && !t2_exp)
        begin
            r_next.t2 = r_reg.t2 + 8'h01;
        end
        case (r_reg.seq)
            IDLE:
            begin
                if (rise[`IN_STOP] && !comm)
                begin
                    r_next.t1 = 8'h00;
                    r_next.t2 = 8'h00;
                    r_next.seq = r_reg.filt[`IN_OVR] ? OVRD : ARMED;
                end
            end
            ARMED:
            begin
                // Sensor two first covers a dead sensor one.
                if (rise[`IN_S2] || t2_exp)
                begin
                    r_next.seq = IDLE;
                end
                else if (rise[`IN_S1] || t1_exp)
                begin
                    r_next.seq = SEG2;
                end
            end
            SEG2:
            begin
                if (rise[`IN_S2] || t2_exp)
                begin
                    r_next.seq = IDLE;
                end
            end
            OVRD:
            begin
                if (t2_exp)
                begin
                    r_next.seq = IDLE;
                end
            end
            default:
            begin
                r_next.seq = IDLE;
            end
        endcase
        if (comm || r_reg.ctrl[`CTRL_CLEAR])
        begin
            r_next.seq = IDLE;
            r_next.t1 = 8'h00;
            r_next.t2 = 8'h00;
        end
        r_next.ctrl[`CTRL_CLEAR] = 1'b0;

        // ======================================================
        // Failure handling
        if (!comm)
        begin
            r_next.fs_cnt = 10'h000;
            r_next.fs_off = 1'b0;
        end
        else if (tick && !r_reg.fs_off)
        begin
            r_next.fs_cnt = r_reg.fs_cnt + 10'h001;
            r_next.fs_off = (r_next.fs_cnt == `FAILSAFE_S);
        end
        if (comm && r_reg.filt[`IN_LSEL])
        begin
            fail_on = r_reg.filt[`IN_LON];
        end
        else if (r_reg.ctrl[`CTRL_BY_VIS])
        begin
            fail_on = low_vis;
        end
        else
        begin
            fail_on = r_reg.ctrl[`CTRL_REMOTE_ON];
        end

        // ======================================================
        // Lamp drive; each lamp is gated only by its own device.
        // Without comm failure, outside combined mode or in low visibility, the red bar is lit at rest and again once sensor one has passed.
        bar = (r_next.seq == IDLE) || (r_next.seq == SEG2);
        if (comm)
        begin
            r_next.seg1 = 1'b0;
            r_next.seg2 = 1'b0;
            r_next.red = (fail_on && !r_reg.fs_off) ? ~devf : 8'h00;
            r_next.yel = (combo && !fail_on) ?
                ((r_reg.pulse ? 8'h55 : 8'hAA) & ~devf) : 8'h00;
        end
        else
        begin
            r_next.seg1 = (r_next.seq == ARMED) || (r_next.seq == OVRD);
            r_next.seg2 = (r_next.seq != IDLE);
            r_next.red = (bar && (!combo || low_vis)) ? ~devf : 8'h00;
            r_next.yel = (combo && !low_vis) ?
                ((r_reg.pulse ? 8'h55 : 8'hAA) & ~devf) : 8'h00;
        end
        // Device failure forces both colours off.
        r_next.red = r_next.red & ~devf;
        r_next.yel = r_next.yel & ~devf;
        r_next.lstat = (r_next.red | r_next.yel) & ~badf;

        // Monitoring summary.
        nfail = 4'h0;
        adj = 1'b0;
        for (int i = 0; i < LAMPS; i++)
        begin
            nfail = nfail + {3'h0, badf[i]};
            if (i > 0)
            begin
                adj = adj | (badf[i] & badf[i-1]);
            end
        end

        // ======================================================
        // AHB-Lite slave: zero wait, read data registered.
        wr_ok = r_reg.a_valid && r_reg.a_wr;
        wr_idx = r_reg.a_idx;
        // Only addresses inside the window start a write, so aliases of
        // the four registers never reach them.
        r_next.a_valid = HSEL && HREADY && HTRANS[1]
                         && (HADDR[31:6] == 26'h0);
        r_next.a_wr = HWRITE;
        r_next.a_idx = HADDR[5:2];
        if (wr_ok && wr_idx == `OFF_CTRL)
        begin
            r_next.ctrl = HWDATA[3:0];
        end
        if (wr_ok && wr_idx == `OFF_VIS)
        begin
            r_next.vis = HWDATA[15:0];
        end
        // A clear only sticks once the fault is gone; set wins.
        if (wr_ok && wr_idx == `OFF_SERVICE && HWDATA[0])
        begin
            r_next.failed = 1'b0;
        end
        if (comm || (|devf))
        begin
            r_next.failed = 1'b1;
        end
        case (HADDR[5:2])
            `OFF_CTRL: rd_mux = {28'h0, r_reg.ctrl};
            `OFF_VIS: rd_mux = {16'h0, r_reg.vis};
            `OFF_STATUS: rd_mux = {4'h0, r_reg.t2, r_reg.t1, adj, nfail,
                                   r_reg.failed, comm, r_reg.seg2,
                                   r_reg.seg1, fail_on, r_reg.seq};
            default: rd_mux = 32'h00000000;
        endcase
        if (HADDR[31:6] != 26'h0)
        begin
            rd_mux = 32'h00000000;
        end
        if (HSEL && HREADY && HTRANS[1] && !HWRITE)
        begin
            r_next.rdata = rd_mux;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            r_reg <= '0;
            r_reg.ctrl <= `CTRL_RESET;
            r_reg.vis <= `VIS_RESET;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Checks
    property p_press;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (r_reg.seq == IDLE && rise[`IN_STOP] && !comm
         && !r_reg.filt[`IN_OVR] && !r_reg.ctrl[`CTRL_CLEAR])
        |=> (r_reg.seq == ARMED && r_reg.t1 == 8'h00 && r_reg.t2 == 8'h00);
    endproperty
    a_press: assert property (p_press)
        else $error("press did not arm the sequence");

    property p_resp;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (r_reg.seq == IDLE && rise[`IN_STOP] && !comm
         && !r_reg.ctrl[`CTRL_CLEAR])
        |-> ##[1:`RESP_CYCLES] (r_reg.red == 8'h00 && r_reg.seg1
                                && r_reg.seg2);
    endproperty
    a_resp: assert property (p_resp)
        else $error("lights not switched after press");

    property p_t1;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (r_reg.seq == ARMED && t1_exp && !rise[`IN_S2] && !t2_exp
         && !comm && !r_reg.ctrl[`CTRL_CLEAR]) |=> r_reg.seq == SEG2;
    endproperty
    a_t1: assert property (p_t1)
        else $error("timer one expiry ignored");

    property p_s2_early;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (r_reg.seq == ARMED && rise[`IN_S2])
        |=> (r_reg.seq == IDLE && !r_reg.seg1 && !r_reg.seg2);
    endproperty
    a_s2_early: assert property (p_s2_early)
        else $error("early sensor two did not reset");

    property p_s1;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (r_reg.seq == ARMED && rise[`IN_S1] && !rise[`IN_S2] && !t2_exp
         && !comm && !r_reg.ctrl[`CTRL_CLEAR])
        |=> (r_reg.seq == SEG2 && !r_reg.seg1 && r_reg.seg2);
    endproperty
    a_s1: assert property (p_s1)
        else $error("sensor one did not advance");

    property p_ovr;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (r_reg.seq == OVRD && !t2_exp && !comm
         && !r_reg.ctrl[`CTRL_CLEAR]) |=> r_reg.seq == OVRD;
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("override left early");

    property p_t2;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (r_reg.seq != IDLE && t2_exp) |=> r_reg.seq == IDLE;
    endproperty
    a_t2: assert property (p_t2)
        else $error("timer two expiry ignored");

    property p_dev;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        ((r_reg.red | r_reg.yel) & $past(devf)) == 8'h00;
    endproperty
    a_dev: assert property (p_dev)
        else $error("lamp on behind failed device");

    property p_failed;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        (r_reg.failed && comm) |=> r_reg.failed;
    endproperty
    a_failed: assert property (p_failed)
        else $error("failed indication dropped");
endmodule : stop_bar_sequence_controller

// ### hw/stop_bar_cfg.svh
`ifndef STOP_BAR_CFG_SVH
`define STOP_BAR_CFG_SVH
// ==========================================================
// Register map
`define OFF_CTRL 4'h0
`define OFF_VIS 4'h1
`define OFF_STATUS 4'h2
`define OFF_SERVICE 4'h3
`define CTRL_REMOTE_ON 0
`define CTRL_BY_VIS 1
`define CTRL_COMBO 2
`define CTRL_CLEAR 3
`define CTRL_RESET 4'h2
`define VIS_RESET 16'h0000
// ==========================================================
// Timing
`define CLK_HZ 40000000
`define TICK_S 1
`define T1_S 8'h2D
`define T2_S 8'h78
`define FAILSAFE_S 10'h258
`define VIS_LIMIT_FT 16'h04B0
`define RESP_CYCLES 2
// ==========================================================
// Synchronised input positions
`define IN_STOP 0
`define IN_OVR 1
`define IN_S1 2
`define IN_S2 3
`define IN_COMM 4
`define IN_LSEL 5
`define IN_LON 6
`define IN_LAMP 7
`define IN_DEV 15
`endif

// ### hw/stop_bar_pkg.sv
package stop_bar_pkg;
    localparam int LAMPS = 8;
    localparam int NIN = 23;
    typedef logic [LAMPS-1:0] lamp_t;
    typedef logic [NIN-1:0] in_t;
    typedef enum logic [1:0] {IDLE, ARMED, SEG2, OVRD} seq_e;
    typedef struct packed {
        in_t s1;
        in_t s2;
        in_t s3;
        in_t filt;
        in_t prev;
        logic [25:0] presc;
        logic pulse;
        seq_e seq;
        logic [7:0] t1;
        logic [7:0] t2;
        logic [9:0] fs_cnt;
        logic fs_off;
        logic [3:0] ctrl;
        logic [15:0] vis;
        logic failed;
        logic [31:0] rdata;
        logic [3:0] a_idx;
        logic a_wr;
        logic a_valid;
        lamp_t red;
        lamp_t yel;
        lamp_t lstat;
        logic seg1;
        logic seg2;
    } state_s;
endpackage : stop_bar_pkg

// ### verif/stop_bar_field.sv
`timescale 1ns/1ps
module stop_bar_field (
    input wire logic clk,
    input wire logic [3:0] ev,
    output logic stop_btn,
    output logic ovr_btn,
    output logic det1,
    output logic det2
);
    int cnt [4] = '{0, 0, 0, 0};
    // ==========================================================
    // Panel buttons and presence sensors
    // Each line is held for several cycles so that the input filter
    // sees a settled level; override stays up long enough to span a press.
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (ev[i])
                cnt[i] <= (i == 1) ? 24 : 6;
            else if (cnt[i] > 0)
                cnt[i] <= cnt[i] - 1;
        end
    end
    assign stop_btn = cnt[0] > 0;
    assign ovr_btn = cnt[1] > 0;
    assign det1 = cnt[2] > 0;
    assign det2 = cnt[3] > 0;
endmodule : stop_bar_field

// ### verif/test_stop_bar_sequence_controller.sv
`timescale 1ns/1ps
module test_stop_bar_sequence_controller;
    import stop_bar_pkg::*;
    localparam int TK = 8;
    logic CORE_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic HREADY;
    logic STOP_BUTTON, OVERRIDE_BUTTON, SENSOR1, SENSOR2;
    logic COMM_FAIL = 1'b0;
    logic LOCAL_SEL = 1'b0;
    logic LOCAL_ON = 1'b0;
    logic [7:0] LAMP_FAIL = 8'h00;
    logic [7:0] DEV_FAIL = 8'h00;
    logic [7:0] STOP_BAR_LAMP, GUARD_LAMP_ROW, LAMP_STATUS;
    logic LEAD_SEG1, LEAD_SEG2, FAIL_IND;
    logic [3:0] ev = 4'h0;
    logic [31:0] rdat;
    logic [7:0] lf, dv;
    int n_mismatch = 0;
    int samples_checked = 0;
    int evq[$] = '{0, 2, 3, 0, 3};
    int stq[$] = '{1, 2, 0, 1, 0};

    assign HREADY = HREADYOUT;
    always #12.5 CORE_CLK = ~CORE_CLK;

    stop_bar_sequence_controller #(.TICK_CYCLES(TK)) dut (
        .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .STOP_BUTTON(STOP_BUTTON),
        .OVERRIDE_BUTTON(OVERRIDE_BUTTON), .SENSOR1(SENSOR1),
        .SENSOR2(SENSOR2), .COMM_FAIL(COMM_FAIL), .LOCAL_SEL(LOCAL_SEL),
        .LOCAL_ON(LOCAL_ON), .LAMP_FAIL(LAMP_FAIL), .DEV_FAIL(DEV_FAIL),
        .STOP_BAR_LAMP(STOP_BAR_LAMP), .GUARD_LAMP_ROW(GUARD_LAMP_ROW),
        .LEAD_SEG1(LEAD_SEG1), .LEAD_SEG2(LEAD_SEG2),
        .LAMP_STATUS(LAMP_STATUS), .FAIL_IND(FAIL_IND)
    );

    stop_bar_field field (
        .clk(CORE_CLK), .ev(ev), .stop_btn(STOP_BUTTON),
        .ovr_btn(OVERRIDE_BUTTON), .det1(SENSOR1), .det2(SENSOR2)
    );

    // ==========================================================
    // Helpers
    task cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask : cyc

    task tk(input int n);
        cyc(n * TK);
    endtask : tk

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Single AHB-Lite transfer; waits on hready in both phases.
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= a;
        do
            @(posedge CORE_CLK);
        while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do
            @(posedge CORE_CLK);
        while (HREADY !== 1'b1);
        rdat = HRDATA;
    endtask : bus

    task rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rdat);
        chk("hresp", 32'h0, 32'(HRESP));
        chk("hready", 32'h1, 32'(HREADYOUT));
    endtask : rchk

    task fire(input int i);
        ev[i] <= 1'b1;
        @(posedge CORE_CLK);
        ev <= 4'h0;
        cyc(12);
    endtask : fire

    // Reference: 0 idle, 1 armed or override, 2 second segment only.
    task cmp_seq(input int st);
        logic [9:0] e;
        e = (st == 1) ? 10'h003 : {~DEV_FAIL, 1'b0, st == 2};
        chk("lamps", 32'(e), 32'({STOP_BAR_LAMP, LEAD_SEG1, LEAD_SEG2}));
    endtask : cmp_seq

    task end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        #2000000;
        n_mismatch++;
        end_of_test;
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        void'($urandom(4282));
        cyc(2);
        RESET_N <= 1'b1;
        @(posedge CORE_CLK);
        rchk("ctrl", 32'h0, 32'h2);
        rchk("vis", 32'h4, 32'h0);
        rchk("unmapped", 32'h40, 32'h0);
        bus(1'b1, 32'h4, 32'h64);
        lf = 8'($urandom);
        LAMP_FAIL <= lf;
        cyc(12);
        chk("status", {24'h000000, ~lf}, 32'(LAMP_STATUS));
        bus(1'b0, 32'h8, 32'h0);
        chk("count", 32'({|(lf & (lf >> 1)), 4'($countones(lf))}),
            32'(rdat[11:7]));
        fire(0);
        chk("status_on", 32'h0, 32'(LAMP_STATUS));
        LAMP_FAIL <= 8'h00;
        fire(3);
        foreach (evq[i])
        begin
            fire(evq[i]);
            cmp_seq(stq[i]);
        end
        // A clear written mid-sequence must drop back to rest at once.
        fire(0);
        bus(1'b1, 32'h0, 32'hA);
        cyc(4);
        cmp_seq(0);
        rchk("ctrl_clr", 32'h0, 32'h2);
        fire(0);
        tk(42);
        cmp_seq(1);
        tk(4);
        cmp_seq(2);
        tk(71);
        cmp_seq(2);
        tk(4);
        cmp_seq(0);
        fire(1);
        fire(0);
        fire(2);
        fire(3);
        cmp_seq(1);
        tk(114);
        cmp_seq(1);
        tk(6);
        cmp_seq(0);
        dv = 8'($urandom);
        DEV_FAIL <= dv;
        COMM_FAIL <= 1'b1;
        cyc(12);
        chk("fail_red", {24'h000000, ~dv}, 32'(STOP_BAR_LAMP));
        chk("fail_ind", 32'h1, 32'(FAIL_IND));
        tk(590);
        chk("fs_red", {24'h000000, ~dv}, 32'(STOP_BAR_LAMP));
        tk(14);
        chk("fs_off", 32'h0, 32'(STOP_BAR_LAMP));
        COMM_FAIL <= 1'b0;
        cyc(12);
        bus(1'b1, 32'hC, 32'h1);
        cyc(4);
        chk("ind_hold", {31'h0, |dv}, 32'(FAIL_IND));
        DEV_FAIL <= 8'h00;
        cyc(12);
        bus(1'b1, 32'hC, 32'h1);
        cyc(4);
        chk("ind_clr", 32'h0, 32'(FAIL_IND));
        bus(1'b1, 32'h4, 32'h4B0);
        COMM_FAIL <= 1'b1;
        cyc(12);
        chk("hi_vis", 32'h0, 32'(STOP_BAR_LAMP));
        bus(1'b1, 32'h0, 32'h1);
        cyc(4);
        chk("remote", 32'hFF, 32'(STOP_BAR_LAMP));
        LOCAL_SEL <= 1'b1;
        cyc(12);
        chk("local", 32'h0, 32'(STOP_BAR_LAMP));
        LOCAL_ON <= 1'b1;
        cyc(12);
        chk("local_on", 32'hFF, 32'(STOP_BAR_LAMP));
        COMM_FAIL <= 1'b0;
        LOCAL_SEL <= 1'b0;
        LOCAL_ON <= 1'b0;
        bus(1'b1, 32'h0, 32'h6);
        DEV_FAIL <= 8'h01;
        cyc(12);
        chk("yel", GUARD_LAMP_ROW[1] ? 32'hAA : 32'h54,
            32'(GUARD_LAMP_ROW));
        lf = GUARD_LAMP_ROW;
        chk("red_good", 32'h0, 32'(STOP_BAR_LAMP));
        COMM_FAIL <= 1'b1;
        tk(1);
        // Exactly one tick later the even and odd halves must have swapped.
        chk("yel_cf", (lf == 8'h54) ? 32'hAA : 32'h54,
            32'(GUARD_LAMP_ROW));
        bus(1'b1, 32'h4, 32'h4AF);
        cyc(4);
        chk("combo_low", 32'hFE,
            32'({STOP_BAR_LAMP | GUARD_LAMP_ROW}));
        chk("yel_low", 32'h0, 32'(GUARD_LAMP_ROW));
        end_of_test;
    end
endmodule : test_stop_bar_sequence_controller
